// >>> logic/rcx_receiver_config.sv
`timescale 1ns/1ps
// Functional notes
// R1 - partial last byte is written to FIFO when allowed, despite checksum check
// R2 - multi-frame mode keeps receiving after a frame until stopped
// R3 - multi-frame mode appends a copy of error flags after each frame
// R4 - end-of-frame select picks configured end symbol or type B end
// R5 - no end-of-frame check when select is 0 and symbol bits are 0
// R6 - guard time check raises protocol error in type B when too long
// R7 - error in first three bytes with suppression drops them, resets FIFO
// R8 - suppressed noise cases never raise receive done
// R9 - host should not read FIFO before three bytes when forcing checksum
// R10 - baud code 2h to 7h selects 26 to 847 kBd, rest reserved
// R11 - hold-off unit is 16 carrier periods or half a bit period
// R12 - after transmit end all input is ignored for hold-off time
// R13 - bit decoder uses decoder minimum threshold field
// R14 - phase detector uses its own minimum threshold field
// R15 - input pin mode selects full or quasi differential input
// R16 - converter mode selects normal reception or low-power card detect
// R17 - signal source field picks idle, analog, envelope or digital input
// R18 - collision level sets 1/8, 1/4, 1/2 sensitivity or disables detection
// R19 - reserved bits read zero, all fields reset to zero except the receive state, which resets to idle (01h)
module rcx_receiver_config (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // register port
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [7:0] regRdata,
  // receive sequencing
  input wire logic txEnd,
  input wire logic rxStart,
  input wire logic rxStop,
  // frame decoder
  input wire logic sofSeen,
  input wire logic byteValid,
  input wire logic [7:0] byteData,
  input wire logic partialValid,
  input wire logic frameEnd,
  input wire logic frameError,
  input wire logic collision,
  input wire logic guardTooLong,
  input wire logic checksumEn,
  input wire logic typeB,
  input wire logic [1:0] eofSymbolCfg,
  input wire logic [7:0] errorFlags,
  // fifo
  output logic fifoWr,
  output logic [7:0] fifoData,
  output logic fifoFlush,
  // receiver controls
  output logic listening,
  output logic holdoffActive,
  output logic eofCheckEn,
  output logic eofTypeB,
  output logic guardCheckEn,
  output logic [2:0] baudCode,
  output logic baudValid,
  output logic [3:0] decoderMinThresh,
  output logic [3:0] phaseMinThresh,
  output logic singleInputPin,
  output logic lowPowerCardDetect,
  output logic [1:0] signalSource,
  output logic [1:0] collisionLevel,
  output logic collisionDetectEn,
  // interrupt
  output logic irq
);

  typedef struct packed {
    logic [7:0] ctrl;
    logic [7:0] hold;
    logic [7:0] thr;
    logic [7:0] incfg;
    rcx_pkg::rcx_state_e st;
    logic [1:0] cnt;
    logic fifoWr;
    logic [7:0] fifoData;
    logic fifoFlush;
    logic [7:0] rdData;
    logic [2:0] ev;
  } rcx_rx_s;

  rcx_rx_s s;
  rcx_rx_s next_s;

  logic [2:0] irqStatus;
  logic [2:0] irqMask;
  logic noise;
  logic holdBusy;

  rcx_hold_if hb();

  // ----------------------------------------
  // submodules
  // ----------------------------------------
  rcx_holdoff u_hold (
    .mclk(mclk),
    .rst(rst),
    .hb(hb.tmr)
  );

  rcx_irq_ctrl u_irq (
    .mclk(mclk),
    .rst(rst),
    .events(s.ev),
    .clrWr(regWr && regAddr == rcx_pkg::ADDR_IRQ_STAT),
    .maskWr(regWr && regAddr == rcx_pkg::ADDR_IRQ_MASK),
    .wrData(regWdata[2:0]),
    .status(irqStatus),
    .mask(irqMask),
    .irq(irq)
  );

  // ----------------------------------------
  // hold-off request
  // ----------------------------------------
  assign hb.start = txEnd && !rxStop; // R12
  assign hb.count = s.hold[6:0];
  assign hb.unitEtu = s.hold[rcx_pkg::HOLD_UNIT]; // R11
  assign hb.halfCyc = rcx_pkg::half_bit_cycles(s.ctrl[2:0]); // R11
  assign holdBusy = hb.busy;

  assign noise = s.ctrl[rcx_pkg::CTRL_SUPP] && s.cnt < rcx_pkg::NOISE_BYTES; // R7

  // ----------------------------------------
  // registers and receive sequence
  // ----------------------------------------
  always_comb begin
    next_s = s;
    next_s.fifoWr = 1'b0;
    next_s.fifoFlush = 1'b0;
    next_s.ev = 3'h0;
    next_s.rdData = 8'h00;
    if (regWr) begin
      if (regAddr == rcx_pkg::ADDR_CTRL) begin
        next_s.ctrl = regWdata;
      end else if (regAddr == rcx_pkg::ADDR_HOLD) begin
        next_s.hold = regWdata;
      end else if (regAddr == rcx_pkg::ADDR_THR) begin
        next_s.thr = regWdata;
      end else if (regAddr == rcx_pkg::ADDR_INCFG) begin
        next_s.incfg = regWdata & rcx_pkg::INCFG_MASK; // R19
      end
    end
    if (regRd) begin
      if (regAddr == rcx_pkg::ADDR_CTRL) begin
        next_s.rdData = s.ctrl;
      end else if (regAddr == rcx_pkg::ADDR_HOLD) begin
        next_s.rdData = s.hold;
      end else if (regAddr == rcx_pkg::ADDR_THR) begin
        next_s.rdData = s.thr;
      end else if (regAddr == rcx_pkg::ADDR_INCFG) begin
        next_s.rdData = s.incfg;
      end else if (regAddr == rcx_pkg::ADDR_IRQ_STAT) begin
        next_s.rdData = {5'h00, irqStatus};
      end else if (regAddr == rcx_pkg::ADDR_IRQ_MASK) begin
        next_s.rdData = {5'h00, irqMask};
      end else if (regAddr == rcx_pkg::ADDR_RX_STAT) begin
        next_s.rdData = {2'h0, s.st};
      end
    end
    if (s.st == rcx_pkg::ST_FRAME && guardTooLong && guardCheckEn) begin
      next_s.ev[rcx_pkg::IRQ_PROT] = 1'b1; // R6
    end
    case (s.st)
      rcx_pkg::ST_IDLE: begin
        if (rxStart) begin
          next_s.st = rcx_pkg::ST_HUNT;
        end
      end
      rcx_pkg::ST_HOLD: begin
        if (!holdBusy) begin
          next_s.st = rcx_pkg::ST_HUNT; // R12
        end
      end
      rcx_pkg::ST_HUNT: begin
        if (sofSeen) begin
          next_s.st = rcx_pkg::ST_FRAME;
          next_s.cnt = 2'h0;
        end
      end
      rcx_pkg::ST_FRAME: begin
        if ((frameError || collision) && noise) begin
          next_s.fifoFlush = 1'b1; // R7
          next_s.ev[rcx_pkg::IRQ_NOISE] = 1'b1;
          next_s.st = rcx_pkg::ST_HUNT;
        end else if (frameEnd) begin
          if (noise) begin
            next_s.fifoFlush = 1'b1; // R8
            next_s.ev[rcx_pkg::IRQ_NOISE] = 1'b1;
            next_s.st = rcx_pkg::ST_HUNT;
          end else begin
            next_s.ev[rcx_pkg::IRQ_DONE] = 1'b1;
            if (s.ctrl[rcx_pkg::CTRL_MULTI]) begin
              next_s.st = rcx_pkg::ST_APPEND; // R2
            end else begin
              next_s.st = rcx_pkg::ST_IDLE;
            end
          end
        end else if (byteValid) begin
          next_s.fifoWr = 1'b1;
          next_s.fifoData = byteData;
          if (s.cnt != rcx_pkg::NOISE_BYTES) begin
            next_s.cnt = s.cnt + 2'h1;
          end
        end else if (partialValid) begin
          if (s.ctrl[rcx_pkg::CTRL_ALLOW] || !checksumEn) begin
            next_s.fifoWr = 1'b1; // R1
            next_s.fifoData = byteData;
            if (s.cnt != rcx_pkg::NOISE_BYTES) begin
              next_s.cnt = s.cnt + 2'h1;
            end
          end
        end
      end
      rcx_pkg::ST_APPEND: begin
        next_s.fifoWr = 1'b1; // R3
        next_s.fifoData = errorFlags;
        next_s.st = rcx_pkg::ST_HUNT;
      end
      default: begin
        next_s.st = rcx_pkg::ST_IDLE;
      end
    endcase
    if (rxStop) begin
      next_s.st = rcx_pkg::ST_IDLE;
    end else if (txEnd) begin
      next_s.st = rcx_pkg::ST_HOLD; // R12
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      s <= '0;
      s.st <= rcx_pkg::ST_IDLE;
    end else begin
      s <= next_s;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign regRdata = s.rdData;
  assign fifoWr = s.fifoWr;
  assign fifoData = s.fifoData;
  assign fifoFlush = s.fifoFlush;
  assign listening = (s.st == rcx_pkg::ST_HUNT) || (s.st == rcx_pkg::ST_FRAME);
  assign holdoffActive = (s.st == rcx_pkg::ST_HOLD);
  assign eofTypeB = s.ctrl[rcx_pkg::CTRL_EOF_SEL]; // R4
  assign eofCheckEn = eofTypeB || (eofSymbolCfg != 2'h0); // R5
  assign guardCheckEn = s.ctrl[rcx_pkg::CTRL_GUARD] && typeB; // R6
  assign baudCode = s.ctrl[2:0]; // R10
  assign baudValid = s.ctrl[2:0] >= rcx_pkg::BAUD_MIN; // R10
  assign decoderMinThresh = s.thr[7:4]; // R13
  assign phaseMinThresh = s.thr[3:0]; // R14
  assign singleInputPin = s.incfg[rcx_pkg::INCFG_SINGLE]; // R15
  assign lowPowerCardDetect = s.incfg[rcx_pkg::INCFG_ADC]; // R16
  assign signalSource = s.incfg[5:4]; // R17
  assign collisionLevel = s.incfg[1:0]; // R18
  assign collisionDetectEn = s.incfg[1:0] != rcx_pkg::COLL_OFF; // R18

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  chk_partial_keep: assert property (s.st == rcx_pkg::ST_FRAME && partialValid // R1
    && !byteValid && !frameEnd && !frameError && !collision && !rxStop && !txEnd
    && s.ctrl[7] |=> fifoWr)
    else $error("partial byte not written");
  chk_partial_drop: assert property (s.st == rcx_pkg::ST_FRAME && partialValid // R1
    && !byteValid && checksumEn && !s.ctrl[7] |=> !fifoWr)
    else $error("partial byte written under checksum");
  chk_multi_stays: assert property (s.st == rcx_pkg::ST_FRAME && frameEnd && !noise // R2
    && s.ctrl[6] && !rxStop && !txEnd |=> s.st == rcx_pkg::ST_APPEND
    ##1 s.st != rcx_pkg::ST_IDLE || $past(rxStop))
    else $error("multi-frame receive stopped");
  chk_error_byte: assert property (s.st == rcx_pkg::ST_APPEND // R3
    |=> fifoWr && fifoData == $past(errorFlags))
    else $error("error byte not appended");
  chk_eof_off: assert property (!s.ctrl[5] && eofSymbolCfg == 2'h0 |-> !eofCheckEn) // R5
    else $error("end check active when disabled");
  chk_noise_flush: assert property (s.st == rcx_pkg::ST_FRAME && noise // R7
    && (frameError || collision) |=> fifoFlush && s.ev[0] == 1'b0)
    else $error("noise not flushed");
  chk_noise_done: assert property (s.st == rcx_pkg::ST_FRAME && noise && frameEnd // R8
    |=> !s.ev[0] ##1 !irqStatus[0] || $past(irqStatus[0], 2))
    else $error("done raised on noise frame");
  chk_baud_reg: assert property (regWr && regAddr == 8'h35 // R10
    |=> baudCode == $past(regWdata[2:0]) && baudValid == ($past(regWdata[2:0]) > 3'h1))
    else $error("baud code not taken");
  chk_hold_ignore: assert property (s.st == rcx_pkg::ST_HOLD && !rxStop // R12
    |=> !fifoWr && s.st != rcx_pkg::ST_FRAME)
    else $error("input taken during hold-off");
  chk_reserved_zero: assert property (s.incfg[3:2] == 2'h0) // R19
    else $error("reserved bits stored");
  chk_guard_err: assert property (s.st == rcx_pkg::ST_FRAME && guardTooLong && typeB // R6
    && s.ctrl[4] |=> ##1 irqStatus[1])
    else $error("guard time error missed");

  chk_eof_type: assert property (regWr && regAddr == 8'h35 // R4
    |=> eofTypeB == $past(regWdata[5]))
    else $error("end type select not taken");
  chk_decoder_thr: assert property (regWr && regAddr == 8'h37 // R13
    |=> decoderMinThresh == $past(regWdata[7:4]))
    else $error("decoder threshold not taken");
  chk_phase_thr: assert property (regWr && regAddr == 8'h37 // R14
    |=> phaseMinThresh == $past(regWdata[3:0]))
    else $error("phase threshold not taken");

  chk_pin_mode: assert property (regWr && regAddr == 8'h38 // R15
    |=> singleInputPin == $past(regWdata[7]))
    else $error("pin mode not taken");
  chk_adc_mode: assert property (regWr && regAddr == 8'h38 // R16
    |=> lowPowerCardDetect == $past(regWdata[6]))
    else $error("converter mode not taken");
  chk_sig_source: assert property (regWr && regAddr == 8'h38 // R17
    |=> signalSource == $past(regWdata[5:4]))
    else $error("signal source not taken");
  chk_coll_level: assert property (regWr && regAddr == 8'h38 // R18
    |=> collisionDetectEn == ($past(regWdata[1:0]) != 2'h3))
    else $error("collision level not taken");

  chk_hold_enter: assert property (txEnd && !rxStop // R12
    |=> holdoffActive)
    else $error("hold-off not entered");
  chk_stop_idle: assert property (rxStop // R2
    |=> s.st == rcx_pkg::ST_IDLE && !listening)
    else $error("receiver not stopped");
  chk_noise_window: assert property (s.st == rcx_pkg::ST_FRAME && s.cnt == 2'h3 // R7
    |=> !fifoFlush)
    else $error("flush after three bytes");

  cov_multi: cover property (s.st == rcx_pkg::ST_APPEND);
  cov_noise: cover property (fifoFlush);
  cov_partial: cover property (s.st == rcx_pkg::ST_FRAME && partialValid && checksumEn);
  cov_hold: cover property (s.st == rcx_pkg::ST_HOLD ##1 s.st == rcx_pkg::ST_HUNT);

endmodule

// >>> logic/rcx_pkg.sv
package rcx_pkg;

  // ----------------------------------------
  // register offsets
  // ----------------------------------------
  localparam logic [7:0] ADDR_CTRL = 8'h35;
  localparam logic [7:0] ADDR_HOLD = 8'h36;
  localparam logic [7:0] ADDR_THR = 8'h37;
  localparam logic [7:0] ADDR_INCFG = 8'h38;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h40;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h41;
  localparam logic [7:0] ADDR_RX_STAT = 8'h42;
  localparam logic [7:0] RESET_VAL = 8'h00;

  // ----------------------------------------
  // field positions and masks
  // ----------------------------------------
  localparam int CTRL_ALLOW = 7;
  localparam int CTRL_MULTI = 6;
  localparam int CTRL_EOF_SEL = 5;
  localparam int CTRL_GUARD = 4;
  localparam int CTRL_SUPP = 3;
  localparam int HOLD_UNIT = 7;
  localparam int INCFG_SINGLE = 7;
  localparam int INCFG_ADC = 6;
  localparam logic [7:0] INCFG_MASK = 8'hF3;
  localparam int IRQ_DONE = 0;
  localparam int IRQ_PROT = 1;
  localparam int IRQ_NOISE = 2;
  localparam int IRQ_W = 3;
  localparam logic [1:0] NOISE_BYTES = 2'h3;
  localparam logic [1:0] COLL_OFF = 2'h3;
  localparam logic [2:0] BAUD_MIN = 3'h2;

  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int MCLK_KHZ = 40000;
  localparam int CARRIER_KHZ = 13560;
  localparam int CARRIER_PER_UNIT = 16;
  localparam logic [9:0] UNIT_CYC =
    10'((CARRIER_PER_UNIT * MCLK_KHZ + CARRIER_KHZ - 1) / CARRIER_KHZ);

  // half bit period in mclk cycles, rounded up
  function automatic logic [9:0] half_bit_cycles(input logic [2:0] code);
    int kbd;
    kbd = 0;
    case (code)
      3'h2: kbd = 26;
      3'h3: kbd = 52;
      3'h4: kbd = 106;
      3'h5: kbd = 212;
      3'h6: kbd = 424;
      3'h7: kbd = 847;
      default: kbd = 0;
    endcase
    if (kbd == 0) begin
      half_bit_cycles = UNIT_CYC;
    end else begin
      half_bit_cycles = 10'((MCLK_KHZ + 2 * kbd - 1) / (2 * kbd));
    end
  endfunction

  typedef enum logic [5:0] {
    ST_IDLE = 6'h01,
    ST_HOLD = 6'h02,
    ST_HUNT = 6'h04,
    ST_FRAME = 6'h08,
    ST_APPEND = 6'h10,
    ST_SPARE = 6'h20
  } rcx_state_e;

endpackage

// >>> logic/rcx_hold_if.sv
`timescale 1ns/1ps
interface rcx_hold_if;
  logic start;
  logic [6:0] count;
  logic unitEtu;
  logic [9:0] halfCyc;
  logic busy;
  modport ctl (output start, count, unitEtu, halfCyc, input busy);
  modport tmr (input start, count, unitEtu, halfCyc, output busy);
endinterface

// >>> logic/rcx_holdoff.sv
`timescale 1ns/1ps
module rcx_holdoff (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // hold-off request and status
  rcx_hold_if.tmr hb
);

  typedef struct packed {
    logic [6:0] rem;
    logic [9:0] tick;
    logic [9:0] unitLen;
    logic busy;
  } rcx_hold_s;

  rcx_hold_s s;
  rcx_hold_s next_s;

  // ----------------------------------------
  // unit counter
  // ----------------------------------------
  always_comb begin
    next_s = s;
    if (hb.start) begin
      next_s.rem = hb.count;
      next_s.tick = 10'h000;
      next_s.unitLen = hb.unitEtu ? hb.halfCyc : rcx_pkg::UNIT_CYC; // R11
      next_s.busy = (hb.count != 7'h00); // R12
    end else if (s.busy) begin
      if (s.tick == s.unitLen - 10'h001) begin
        next_s.tick = 10'h000;
        next_s.rem = s.rem - 7'h01;
        next_s.busy = (s.rem != 7'h01);
      end else begin
        next_s.tick = s.tick + 10'h001;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign hb.busy = s.busy;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  chk_hold_starts: assert property (hb.start && hb.count != 7'h00 |=> s.busy) // R12
    else $error("hold-off did not start");
  chk_hold_unit: assert property (hb.start && !hb.unitEtu |=> s.unitLen == 10'h030) // R11
    else $error("carrier unit length wrong");
  chk_hold_end: assert property ($fell(s.busy) && !$past(hb.start) // R11
    |-> $past(s.rem) == 7'h01 && $past(s.tick) == $past(s.unitLen) - 10'h001)
    else $error("hold-off ended early");
  cov_hold_etu: cover property (hb.start && hb.unitEtu && hb.count != 7'h00);

endmodule

// >>> logic/rcx_irq_ctrl.sv
`timescale 1ns/1ps
module rcx_irq_ctrl (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // events
  input wire logic [2:0] events,
  // register writes
  input wire logic clrWr,
  input wire logic maskWr,
  input wire logic [2:0] wrData,
  // status
  output logic [2:0] status,
  output logic [2:0] mask,
  output logic irq
);

  typedef struct packed {
    logic [2:0] status;
    logic [2:0] mask;
  } rcx_irq_s;

  rcx_irq_s s;
  rcx_irq_s next_s;

  // ----------------------------------------
  // sticky status, write one to clear
  // ----------------------------------------
  always_comb begin
    next_s = s;
    next_s.status = (s.status & ~(clrWr ? wrData : 3'h0)) | events;
    if (maskWr) begin
      next_s.mask = wrData;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign status = s.status;
  assign mask = s.mask;
  assign irq = |(s.status & s.mask);

  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  chk_set_wins: assert property (events[0] && clrWr && wrData[0] |=> status[0])
    else $error("event lost against clear");
  chk_irq_level: assert property (status[0] && mask[0] |-> irq)
    else $error("unmasked status without interrupt");

endmodule

// >>> tb/rcx_card_model.sv
`timescale 1ns/1ps
module rcx_card_model (
  // clock
  input wire logic mclk,
  // decoded card response
  output logic sofSeen,
  output logic byteValid,
  output logic [7:0] byteData,
  output logic partialValid,
  output logic frameEnd,
  output logic frameError,
  output logic collision,
  output logic guardTooLong
);
  // ----------------------------------------
  // one decoder event, one cycle long
  // ----------------------------------------
  // kinds: 0 sof, 1 byte, 2 partial, 3 end, 4 error, 5 collision, 6 guard
  initial begin
    {sofSeen, byteValid, partialValid, frameEnd} = 4'h0;
    {frameError, collision, guardTooLong} = 3'h0;
    byteData = 8'h00;
  end

  task automatic ev(input int k, input logic [7:0] d);
    @(posedge mclk);
    sofSeen <= (k == 0);
    byteValid <= (k == 1);
    partialValid <= (k == 2);
    frameEnd <= (k == 3);
    frameError <= (k == 4);
    collision <= (k == 5);
    guardTooLong <= (k == 6);
    byteData <= d;
    @(posedge mclk);
    {sofSeen, byteValid, partialValid, frameEnd} <= 4'h0;
    {frameError, collision, guardTooLong} <= 3'h0;
    // released data line does not keep its last value
    byteData <= ~d;
  endtask
endmodule

// >>> tb/tb.sv
`timescale 1ns/1ps
module tb;
  // ----------------------------------------
  // signals
  // ----------------------------------------
  logic mclk = 1'b0, rst = 1'b1, regWr = 1'b0, regRd = 1'b0;
  logic [7:0] regAddr = 8'h00, regWdata = 8'h00, errorFlags = 8'h00;
  logic txEnd = 1'b0, rxStart = 1'b0, rxStop = 1'b0, checksumEn = 1'b0, typeB = 1'b0;
  logic [1:0] eofSymbolCfg = 2'h0;
  logic sofSeen, byteValid, partialValid, frameEnd, frameError, collision, guardTooLong;
  logic [7:0] byteData, regRdata, fifoData;
  logic fifoWr, fifoFlush, listening, holdoffActive, eofCheckEn, eofTypeB, guardCheckEn;
  logic baudValid, singleInputPin, lowPowerCardDetect, collisionDetectEn, irq;
  logic [2:0] baudCode;
  logic [3:0] decoderMinThresh, phaseMinThresh;
  logic [1:0] signalSource, collisionLevel;
  logic [7:0] got[$];
  int flushes = 0, mismatches = 0, check_count = 0;

  rcx_card_model u_card (.mclk(mclk), .sofSeen(sofSeen), .byteValid(byteValid),
    .byteData(byteData), .partialValid(partialValid), .frameEnd(frameEnd),
    .frameError(frameError), .collision(collision), .guardTooLong(guardTooLong));

  rcx_receiver_config u_dut (.mclk(mclk), .rst(rst), .regAddr(regAddr),
    .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
    .txEnd(txEnd), .rxStart(rxStart), .rxStop(rxStop), .sofSeen(sofSeen),
    .byteValid(byteValid), .byteData(byteData), .partialValid(partialValid),
    .frameEnd(frameEnd), .frameError(frameError), .collision(collision),
    .guardTooLong(guardTooLong), .checksumEn(checksumEn), .typeB(typeB),
    .eofSymbolCfg(eofSymbolCfg), .errorFlags(errorFlags), .fifoWr(fifoWr),
    .fifoData(fifoData), .fifoFlush(fifoFlush), .listening(listening),
    .holdoffActive(holdoffActive), .eofCheckEn(eofCheckEn), .eofTypeB(eofTypeB),
    .guardCheckEn(guardCheckEn), .baudCode(baudCode), .baudValid(baudValid),
    .decoderMinThresh(decoderMinThresh), .phaseMinThresh(phaseMinThresh),
    .singleInputPin(singleInputPin), .lowPowerCardDetect(lowPowerCardDetect),
    .signalSource(signalSource), .collisionLevel(collisionLevel),
    .collisionDetectEn(collisionDetectEn), .irq(irq));

  always #12.5 mclk = ~mclk;

  // ----------------------------------------
  // fifo monitor
  // ----------------------------------------
  always @(posedge mclk) begin
    if (fifoWr === 1'b1) begin
      got.push_back(fifoData);
    end
    if (fifoFlush === 1'b1) begin
      flushes++;
    end
  end

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    check_count++;
    if (g !== e) begin
      mismatches++;
      $display("[FAIL] t=%0t got %h exp %h", $time, g, e);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    regAddr <= a;
    regWdata <= d;
    regWr <= 1'b1;
    @(posedge mclk);
    regWr <= 1'b0;
  endtask

  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    @(posedge mclk);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge mclk);
    regRd <= 1'b0;
    #1;
    chk(regRdata, e);
  endtask

  // 0 transmit end, 1 arm, 2 stop
  task automatic ctl(input int w);
    @(posedge mclk);
    txEnd <= (w == 0);
    rxStart <= (w == 1);
    rxStop <= (w == 2);
    @(posedge mclk);
    {txEnd, rxStart, rxStop} <= 3'h0;
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset;
    for (int a = 8'h35; a <= 8'h38; a++) rchk(8'(a), 8'h00);
    rchk(rcx_pkg::ADDR_IRQ_STAT, 8'h00);
    rchk(rcx_pkg::ADDR_RX_STAT, 8'h01);
    chk(baudValid, 8'h00);
    chk(collisionDetectEn, 8'h01);
    chk(irq, 8'h00);
  endtask

  task automatic t_regs;
    for (int a = 8'h35; a <= 8'h38; a++) wr(8'(a), 8'hFF);
    wr(8'h50, 8'hFF);
    rchk(rcx_pkg::ADDR_CTRL, 8'hFF);
    rchk(rcx_pkg::ADDR_HOLD, 8'hFF);
    rchk(rcx_pkg::ADDR_INCFG, 8'hF3);
    rchk(8'h50, 8'h00);
    chk(singleInputPin, 8'h01);
    chk(lowPowerCardDetect, 8'h01);
    wr(rcx_pkg::ADDR_THR, 8'h5A);
    rchk(rcx_pkg::ADDR_THR, 8'h5A);
    chk(decoderMinThresh, 8'h05);
    chk(phaseMinThresh, 8'h0A);
    for (int i = 0; i < 4; i++) begin
      wr(rcx_pkg::ADDR_INCFG, 8'(i * 8'h11));
      #1;
      chk(signalSource, 8'(i));
      chk(collisionLevel, 8'(i));
      chk(collisionDetectEn, 8'(i != 3));
      chk(singleInputPin, 8'h00);
      chk(lowPowerCardDetect, 8'h00);
    end
    for (int i = 0; i < 8; i++) begin
      wr(rcx_pkg::ADDR_CTRL, 8'(i));
      #1;
      chk(baudCode, 8'(i));
      chk(baudValid, 8'(i >= 2));
    end
  endtask

  task automatic t_eof;
    for (int s = 0; s < 2; s++) begin
      for (int c = 0; c < 4; c++) begin
        wr(rcx_pkg::ADDR_CTRL, 8'(s * 8'h20 + 8'h10));
        eofSymbolCfg <= 2'(c);
        typeB <= c[0];
        @(posedge mclk);
        #1;
        chk(eofTypeB, 8'(s));
        chk(eofCheckEn, 8'(s == 1 || c != 0));
        chk(guardCheckEn, 8'(c[0]));
      end
    end
  endtask

  task automatic t_hold(input logic [7:0] c, input logic [7:0] h, input int e);
    int n;
    wr(rcx_pkg::ADDR_CTRL, c);
    wr(rcx_pkg::ADDR_HOLD, h);
    got.delete();
    ctl(0);
    u_card.ev(0, 8'h00);
    u_card.ev(1, 8'h77);
    #1;
    chk(holdoffActive, 8'h01);
    n = 4;
    while (holdoffActive === 1'b1 && n < 4000) begin
      @(posedge mclk);
      #1;
      n++;
    end
    chk(8'(n >= e - 3 && n <= e + 3), 8'h01);
    chk(8'(got.size()), 8'h00);
    chk(listening, 8'h01);
    ctl(2);
  endtask

  task automatic t_frame(input logic allow);
    got.delete();
    checksumEn <= 1'b1;
    wr(rcx_pkg::ADDR_CTRL, {allow, 7'h04});
    wr(rcx_pkg::ADDR_IRQ_MASK, 8'h07);
    ctl(1);
    u_card.ev(0, 8'h00);
    for (int i = 1; i < 4; i++) u_card.ev(1, 8'(i * 8'h11));
    u_card.ev(2, 8'h44);
    u_card.ev(3, 8'h00);
    repeat (4) @(posedge mclk);
    chk(8'(got.size()), allow ? 8'h04 : 8'h03);
    for (int i = 0; i < got.size(); i++) chk(got[i], 8'((i + 1) * 8'h11));
    rchk(rcx_pkg::ADDR_IRQ_STAT, 8'h01);
    chk(irq, 8'h01);
    chk(listening, 8'h00);
    wr(rcx_pkg::ADDR_IRQ_STAT, 8'h01);
    repeat (3) @(posedge mclk);
    chk(irq, 8'h00);
  endtask

  task automatic t_multi;
    got.delete();
    wr(rcx_pkg::ADDR_CTRL, 8'h44);
    ctl(1);
    for (int f = 0; f < 2; f++) begin
      errorFlags <= f ? 8'h3C : 8'hA5;
      u_card.ev(0, 8'h00);
      for (int i = 0; i < 3; i++) u_card.ev(1, 8'(i + 1));
      u_card.ev(3, 8'h00);
      repeat (4) @(posedge mclk);
      chk(8'(got.size()), 8'(4 * f + 4));
      chk(got[4 * f + 3], f ? 8'h3C : 8'hA5);
      chk(listening, 8'h01);
    end
    ctl(2);
    #1;
    chk(listening, 8'h00);
    wr(rcx_pkg::ADDR_IRQ_STAT, 8'h07);
  endtask

  // the host side never reads the fifo here
  task automatic t_noise;
    wr(rcx_pkg::ADDR_CTRL, 8'h0C);
    for (int k = 0; k < 3; k++) begin
      flushes = 0;
      wr(rcx_pkg::ADDR_IRQ_STAT, 8'h07);
      ctl(1);
      u_card.ev(0, 8'h00);
      u_card.ev(1, 8'h5A);
      u_card.ev(k == 2 ? 1 : 4 + k, 8'h5B);
      if (k == 2) u_card.ev(3, 8'h00);
      repeat (4) @(posedge mclk);
      chk(8'(flushes), 8'h01);
      rchk(rcx_pkg::ADDR_IRQ_STAT, 8'h04);
      ctl(2);
    end
  endtask

  task automatic t_guard;
    wr(rcx_pkg::ADDR_CTRL, 8'h14);
    for (int t = 0; t < 2; t++) begin
      typeB <= t[0];
      wr(rcx_pkg::ADDR_IRQ_MASK, 8'h05);
      wr(rcx_pkg::ADDR_IRQ_STAT, 8'h07);
      ctl(1);
      u_card.ev(0, 8'h00);
      u_card.ev(6, 8'h00);
      repeat (4) @(posedge mclk);
      rchk(rcx_pkg::ADDR_IRQ_STAT, t ? 8'h02 : 8'h00);
      chk(irq, 8'h00);
      wr(rcx_pkg::ADDR_IRQ_MASK, 8'h07);
      repeat (2) @(posedge mclk);
      chk(irq, 8'(t));
      ctl(2);
    end
  endtask

  // ----------------------------------------
  // run control
  // ----------------------------------------
  task automatic summarize;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  initial begin
    #(25 * 20000);
    mismatches++;
    summarize();
  end

  initial begin
    repeat (20) @(posedge mclk);
    rst <= 1'b0;
    t_reset();
    t_regs();
    t_eof();
    t_hold(8'h07, 8'h02, 96);
    t_hold(8'h07, 8'h83, 72);
    t_hold(8'h02, 8'h84, 3080);
    t_frame(1'b0);
    t_frame(1'b1);
    t_multi();
    t_noise();
    t_guard();
    summarize();
  end
endmodule
